// ---- rdmaq_pkg.sv ----
/*
  Constants, field layout and types of the receive DMA queue control block.
  Assumes a 32-bit register port on the 10 MHz system clock.
*/
package rdmaq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;
  localparam logic [11:0] OFS_CTRL   = 12'h280;
  localparam logic [11:0] OFS_PROVISION_FLAG   = 12'h284;
  localparam logic [11:0] OFS_TBL_LO = 12'h288;
  localparam logic [11:0] OFS_TBL_HI = 12'h28c;
  localparam logic [3:0]  BE_NONE_N  = 4'hf;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int           CTL_W          = 13;
  localparam int           CTL_EN_BIT     = 0;
  localparam int           CTL_LARGE_REF_CACHE_EN_BIT = 1;
  localparam int           CTL_SMALL_REF_CACHE_EN_BIT = 2;
  localparam int           CTL_RAW_LSB    = 3;
  localparam int           CTL_RDY_LSB    = 5;
  localparam int           CTL_LF_LSB     = 8;
  localparam int           CTL_SF_LSB     = 10;
  localparam logic [12:0]  CTL_RESET      = 13'h001e;

  // ----------------------------------------------------------------
  // Indirect provisioning register fields
  // ----------------------------------------------------------------
  localparam int PRV_CHANNEL_SELECT_LSB = 0;
  localparam int PRV_RSV_LSB  = 8;
  localparam int PRV_FLAG_BIT = 10;
  localparam int PRV_DIR_BIT  = 14;
  localparam int PRV_BUSY_BIT = 15;

  // ----------------------------------------------------------------
  // Table base and descriptor address
  // ----------------------------------------------------------------
  localparam int TBL_HALF_W = 16;
  localparam int DESC_OFS_W = 15;
  localparam int TBL_ALIGN  = 4;

  // ----------------------------------------------------------------
  // Threshold counts and fetch groups
  // ----------------------------------------------------------------
  localparam int          CNT_W        = 6;
  localparam logic [5:0]  RDY_CNT_0    = 6'h01;
  localparam logic [5:0]  RDY_CNT_1    = 6'h04;
  localparam logic [5:0]  RDY_CNT_2    = 6'h06;
  localparam logic [5:0]  RDY_CNT_3    = 6'h08;
  localparam logic [5:0]  RDY_CNT_4    = 6'h10;
  localparam logic [5:0]  RDY_CNT_5    = 6'h20;
  localparam logic [5:0]  FREE_CNT_0   = 6'h01;
  localparam logic [5:0]  FREE_CNT_1   = 6'h04;
  localparam logic [5:0]  FREE_CNT_2   = 6'h08;
  localparam logic [5:0]  RSVD_CNT     = 6'h01;
  localparam logic [2:0]  FETCH_GROUP  = 3'h6;
  localparam logic [2:0]  FETCH_SINGLE = 3'h1;

  typedef enum logic [1:0] {
    RDMAQ_IDLE  = 2'b00,
    RDMAQ_FLUSH = 2'b01,
    RDMAQ_QUERY = 2'b10,
    RDMAQ_PROVISION_FLAG  = 2'b11
  } rdmaq_state_t;

endpackage

// ---- rdmaq_thresh.sv ----
/*
  Event counter with a deferred limit: fires a one-cycle pulse after
  the active count of events, then adopts the newest programmed limit.
  Assumes inc is a one-cycle event pulse on the system clock.
*/
`timescale 1ns/100ps
module rdmaq_thresh
  import rdmaq_pkg::*;
#(
  parameter logic [5:0] RST_LIMIT = 6'h01
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             inc,
  input  wire logic [CNT_W-1:0] live_limit,
  output logic                  fire
);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] limit_q;
  logic             fire_q;
  logic [CNT_W-1:0] cnt_inc;
  logic             hit;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  assign cnt_inc = count_q + 6'h01;
  assign hit     = inc && (cnt_inc == limit_q);
  assign fire    = fire_q;

  // Limit only reloads when the count is reached, so a rewrite mid-count is deferred
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 6'h00;
      limit_q <= RST_LIMIT;
      fire_q  <= 1'b0;
    end else begin
      fire_q <= hit;
      if (hit) begin
        count_q <= 6'h00;
        limit_q <= live_limit;
      end else if (inc) begin
        count_q <= cnt_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  thresh_fire_a: assert property (@(posedge clk) disable iff (!rst_n)
    hit |=> fire && count_q == 6'h00 && limit_q == $past(live_limit))
    else $error("threshold reached without event");
  limit_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !hit |=> $stable(limit_q))
    else $error("limit changed between events");
  fire_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    fire |-> $past(inc) && count_q == 6'h00)
    else $error("event pulse without counted input");

endmodule

// ---- rdmaq_top.sv ----
/*
  Receive DMA queue control: control register, indirect channel
  provisioning, descriptor table base and threshold event generation.
  Assumes single-cycle register strobes on the system clock and pulse
  events from the surrounding DMA datapath.
*/
`timescale 1ns/100ps
module rdmaq_top
  import rdmaq_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [3:0]            byte_enable_n,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  output logic [DATA_W-1:0]          reg_rdata,
  output logic                       rx_dma_enable,
  output logic [2:0]                 large_fetch_max,
  output logic [2:0]                 small_fetch_max,
  input  wire logic                  raw_buf_filled,
  output logic                       raw_chain_ready,
  input  wire logic                  rdy_ref_pushed,
  output logic                       ready_queue_irq,
  input  wire logic                  large_free_block_read,
  output logic                       large_free_queue_irq,
  input  wire logic                  small_free_block_read,
  output logic                       small_free_queue_irq,
  output logic                       unprov_req,
  output logic [7:0]                 unprov_channel_select,
  input  wire logic                  unprov_done,
  input  wire logic [DESC_OFS_W-1:0] desc_offset,
  output logic [DATA_W-1:0]          descriptor_table_base,
  output logic [DATA_W-1:0]          desc_addr
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic                  acc_ok;
  logic                  wr_hit;
  logic                  ctrl_we;
  logic                  provision_flag_we;
  logic                  lo_we;
  logic                  hi_we;

  // Byte lanes are not honoured; only the all-off case blocks access
  assign acc_ok  = (byte_enable_n != BE_NONE_N);
  assign wr_hit  = reg_wr && acc_ok;
  assign ctrl_we = wr_hit && (reg_addr == OFS_CTRL);
  assign provision_flag_we = wr_hit && (reg_addr == OFS_PROVISION_FLAG);
  assign lo_we   = wr_hit && (reg_addr == OFS_TBL_LO);
  assign hi_we   = wr_hit && (reg_addr == OFS_TBL_HI);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [CTL_W-1:0] ctrl_q;
  logic [1:0]       raw_limit;
  logic [2:0]       rdy_code;
  logic [1:0]       lf_code;
  logic [1:0]       sf_code;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTL_RESET;
    end else if (ctrl_we) begin
      ctrl_q <= reg_wdata[CTL_W-1:0];
    end
  end

  assign raw_limit = ctrl_q[CTL_RAW_LSB +: 2];
  assign rdy_code  = ctrl_q[CTL_RDY_LSB +: 3];
  assign lf_code   = ctrl_q[CTL_LF_LSB +: 2];
  assign sf_code   = ctrl_q[CTL_SF_LSB +: 2];
  assign rx_dma_enable = ctrl_q[CTL_EN_BIT];

  // ----------------------------------------------------------------
  // Free queue fetch grouping
  // ----------------------------------------------------------------
  logic [2:0] large_fetch_q;
  logic [2:0] small_fetch_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      large_fetch_q <= FETCH_GROUP;
      small_fetch_q <= FETCH_GROUP;
    end else begin
      large_fetch_q <= ctrl_q[CTL_LARGE_REF_CACHE_EN_BIT] ? FETCH_GROUP
                                              : FETCH_SINGLE;
      small_fetch_q <= ctrl_q[CTL_SMALL_REF_CACHE_EN_BIT] ? FETCH_GROUP
                                              : FETCH_SINGLE;
    end
  end

  assign large_fetch_max = large_fetch_q;
  assign small_fetch_max = small_fetch_q;

  // ----------------------------------------------------------------
  // Raw data chaining
  // ----------------------------------------------------------------
  logic [1:0] raw_cnt_q;
  logic       raw_ready_q;
  logic       raw_step;
  logic       raw_wrap;

  // Raw buffers only count while the engine is writing to the host
  assign raw_step = raw_buf_filled && rx_dma_enable;
  assign raw_wrap = raw_step && (raw_cnt_q == raw_limit);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_cnt_q   <= 2'h0;
      raw_ready_q <= 1'b0;
    end else begin
      raw_ready_q <= raw_wrap;
      if (raw_wrap) begin
        raw_cnt_q <= 2'h0;
      end else if (raw_step) begin
        raw_cnt_q <= raw_cnt_q + 2'h1;
      end
    end
  end

  assign raw_chain_ready = raw_ready_q;

  // ----------------------------------------------------------------
  // Threshold events
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] rdy_live;
  logic [CNT_W-1:0] lf_live;
  logic [CNT_W-1:0] sf_live;

  // Reserved codes fall back to a count of one
  assign rdy_live = (rdy_code == 3'h0) ? RDY_CNT_0 :
                    (rdy_code == 3'h1) ? RDY_CNT_1 :
                    (rdy_code == 3'h2) ? RDY_CNT_2 :
                    (rdy_code == 3'h3) ? RDY_CNT_3 :
                    (rdy_code == 3'h4) ? RDY_CNT_4 :
                    (rdy_code == 3'h5) ? RDY_CNT_5 : RSVD_CNT;
  assign lf_live  = (lf_code == 2'h0) ? FREE_CNT_0 :
                    (lf_code == 2'h1) ? FREE_CNT_1 :
                    (lf_code == 2'h2) ? FREE_CNT_2 : RSVD_CNT;
  assign sf_live  = (sf_code == 2'h0) ? FREE_CNT_0 :
                    (sf_code == 2'h1) ? FREE_CNT_1 :
                    (sf_code == 2'h2) ? FREE_CNT_2 : RSVD_CNT;

  rdmaq_thresh #(.RST_LIMIT(RDY_CNT_0)) u_rdy_thresh (
    .clk        (clk),
    .rst_n      (rst_n),
    .inc        (rdy_ref_pushed),
    .live_limit (rdy_live),
    .fire       (ready_queue_irq)
  );

  rdmaq_thresh #(.RST_LIMIT(FREE_CNT_0)) u_lf_thresh (
    .clk        (clk),
    .rst_n      (rst_n),
    .inc        (large_free_block_read),
    .live_limit (lf_live),
    .fire       (large_free_queue_irq)
  );

  rdmaq_thresh #(.RST_LIMIT(FREE_CNT_0)) u_sf_thresh (
    .clk        (clk),
    .rst_n      (rst_n),
    .inc        (small_free_block_read),
    .live_limit (sf_live),
    .fire       (small_free_queue_irq)
  );

  // ----------------------------------------------------------------
  // Indirect channel provisioning
  // ----------------------------------------------------------------
  rdmaq_state_t st_q;
  rdmaq_state_t st_d;
  logic [7:0]   channel_select_q;
  logic [1:0]   prv_rsv_q;
  logic         flag_q;
  logic         dir_q;
  logic         busy;
  logic         provision_flag_trig;

  assign busy      = (st_q != RDMAQ_IDLE);
  // A trigger while busy is dropped; software polls busy first
  assign provision_flag_trig = provision_flag_we && !busy;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      RDMAQ_IDLE: begin
        if (provision_flag_trig) begin
          if (reg_wdata[PRV_DIR_BIT]) begin
            st_d = RDMAQ_QUERY;
          end else if (reg_wdata[PRV_FLAG_BIT]) begin
            st_d = RDMAQ_PROVISION_FLAG;
          end else begin
            st_d = RDMAQ_FLUSH;
          end
        end
      end
      RDMAQ_FLUSH: begin
        if (unprov_done) begin
          st_d = RDMAQ_IDLE;
        end
      end
      RDMAQ_QUERY: begin
        st_d = RDMAQ_IDLE;
      end
      RDMAQ_PROVISION_FLAG: begin
        st_d = RDMAQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= RDMAQ_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_select_q    <= 8'h00;
      prv_rsv_q <= 2'h0;
      flag_q    <= 1'b0;
      dir_q     <= 1'b0;
    end else if (provision_flag_trig) begin
      channel_select_q    <= reg_wdata[PRV_CHANNEL_SELECT_LSB +: 8];
      prv_rsv_q <= reg_wdata[PRV_RSV_LSB +: 2];
      flag_q    <= reg_wdata[PRV_FLAG_BIT];
      dir_q     <= reg_wdata[PRV_DIR_BIT];
    end else if (st_q == RDMAQ_QUERY) begin
      // Channels are never left unprovisioned, so a query reads high
      flag_q    <= 1'b1;
    end
  end

  // Flush request holds until the datapath reports the flush done
  assign unprov_req  = (st_q == RDMAQ_FLUSH);
  assign unprov_channel_select = channel_select_q;

  // ----------------------------------------------------------------
  // Descriptor table base
  // ----------------------------------------------------------------
  logic [TBL_HALF_W-1:0] tbl_hold_q;
  logic [DATA_W-1:0]     tbl_base_q;
  logic [DATA_W-1:0]     desc_addr_q;
  logic [27:0]           desc_sum;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_hold_q <= 16'h0000;
      tbl_base_q <= 32'h0000_0000;
    end else begin
      if (lo_we) begin
        tbl_hold_q <= reg_wdata[TBL_HALF_W-1:0];
      end
      if (hi_we) begin
        tbl_base_q <= {reg_wdata[TBL_HALF_W-1:0], tbl_hold_q};
      end
    end
  end

  // Base bits 3:0 are ignored so a misaligned write cannot skew lookups
  assign desc_sum = tbl_base_q[DATA_W-1:TBL_ALIGN]
                  + {13'h0000, desc_offset};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      desc_addr_q <= 32'h0000_0000;
    end else begin
      desc_addr_q <= {desc_sum, 4'h0};
    end
  end

  assign descriptor_table_base = tbl_base_q;
  assign desc_addr             = desc_addr_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] provision_flag_word;
  logic [DATA_W-1:0] rdata_q;

  assign provision_flag_word = {16'h0000, busy, dir_q, 3'h0, flag_q,
                      prv_rsv_q, channel_select_q};
  assign rd_mux = !acc_ok                  ? 32'h0000_0000 :
                  (reg_addr == OFS_CTRL)   ? {19'h00000, ctrl_q} :
                  (reg_addr == OFS_PROVISION_FLAG)   ? provision_flag_word :
                  (reg_addr == OFS_TBL_LO) ? {16'h0000, tbl_hold_q} :
                  (reg_addr == OFS_TBL_HI) ? {16'h0000,
                                              tbl_base_q[31:16]} :
                                             32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_trig_query;
    provision_flag_trig && reg_wdata[PRV_DIR_BIT];
  endsequence
  sequence s_query_done;
    busy ##1 (!busy && flag_q);
  endsequence

  be_block_a: assert property (
    reg_wr && byte_enable_n == BE_NONE_N |=> $stable(ctrl_q))
    else $error("write with no byte enables changed control");
  enable_out_a: assert property (
    ctrl_we |=> rx_dma_enable == $past(reg_wdata[CTL_EN_BIT]))
    else $error("enable output did not follow write");
  lfetch_sel_a: assert property (
    ##1 large_fetch_max == ($past(ctrl_q[CTL_LARGE_REF_CACHE_EN_BIT]) ?
                            FETCH_GROUP : FETCH_SINGLE))
    else $error("large fetch group wrong");
  sfetch_sel_a: assert property (
    ##1 small_fetch_max == ($past(ctrl_q[CTL_SMALL_REF_CACHE_EN_BIT]) ?
                            FETCH_GROUP : FETCH_SINGLE))
    else $error("small fetch group wrong");
  raw_chain_a: assert property (
    raw_chain_ready |-> $past(raw_step) &&
                        $past(raw_cnt_q) == $past(raw_limit))
    else $error("raw chain closed at wrong count");
  trig_busy_a: assert property (
    provision_flag_trig |=> busy)
    else $error("busy not set by trigger");
  query_done_a: assert property (
    s_trig_query |=> s_query_done)
    else $error("query did not finish in two cycles");
  flush_hold_a: assert property (
    st_q == RDMAQ_FLUSH && !unprov_done |=> unprov_req && busy)
    else $error("flush request dropped early");
  channel_select_keep_a: assert property (
    !provision_flag_trig |=> $stable(channel_select_q))
    else $error("channel field changed without trigger");
  base_hold_a: assert property (
    lo_we && !hi_we |=> $stable(tbl_base_q))
    else $error("low base write reached active base");
  base_load_a: assert property (
    hi_we |=> tbl_base_q == {$past(reg_wdata[15:0]), $past(tbl_hold_q)})
    else $error("upper base write did not load base");
  desc_addr_a: assert property (
    ##1 desc_addr == {$past(tbl_base_q[31:4]) + {13'h0000,
                      $past(desc_offset)}, 4'h0})
    else $error("descriptor address wrong");

endmodule

// ---- rdmaq_far.sv ----
/*
  Far-side model: datapath flush engine answering unprovision requests.
  Assumes the design holds unprov_req until it sees unprov_done.
*/
`timescale 1ns/100ps
module rdmaq_far (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       unprov_req,
  input  wire logic [3:0] dly,
  output logic            unprov_done
);
  logic [3:0] cnt_q;

  // Flush takes dly+1 cycles; a slow flush keeps busy up for a while
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q       <= 4'h0;
      unprov_done <= 1'b0;
    end else begin
      unprov_done <= 1'b0;
      if (unprov_req && !unprov_done) begin
        unprov_done <= (cnt_q == dly);
        cnt_q       <= (cnt_q == dly) ? 4'h0 : cnt_q + 4'h1;
      end
    end
  end
endmodule

// ---- testbench.sv ----
/*
  Self-checking bench for the receive DMA queue control block.
  Assumes rdmaq_pkg, rdmaq_top and the far-side model rdmaq_far.
*/
`timescale 1ns/100ps
module testbench;
  import rdmaq_pkg::*;
  logic        clk, rst_n, reg_wr, reg_rd, up_done;
  logic [11:0] reg_addr;
  logic [3:0]  be_n, ev, dly;
  logic [31:0] wd, rd_q, rv, base, base_x, desc_addr;
  logic [14:0] ofs;
  logic [15:0] lo_w;
  logic [12:0] ctl;
  logic [7:0]  uchan;
  logic [2:0]  lfm, sfm;
  wire  [3:0]  irq;
  logic        en, ureq;
  int          n_errors, checks_done, old, c;
  byte         rc[8] = '{1, 5, 0, 3, 7, 2, 4, 6};

  rdmaq_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .byte_enable_n(be_n),
    .reg_wdata(wd), .reg_rdata(rd_q), .rx_dma_enable(en),
    .large_fetch_max(lfm), .small_fetch_max(sfm),
    .raw_buf_filled(ev[3]), .raw_chain_ready(irq[3]),
    .rdy_ref_pushed(ev[0]), .ready_queue_irq(irq[0]),
    .large_free_block_read(ev[1]), .large_free_queue_irq(irq[1]),
    .small_free_block_read(ev[2]), .small_free_queue_irq(irq[2]),
    .unprov_req(ureq), .unprov_channel_select(uchan), .unprov_done(up_done),
    .desc_offset(ofs), .descriptor_table_base(base),
    .desc_addr(desc_addr));
  rdmaq_far far (.clk(clk), .rst_n(rst_n), .unprov_req(ureq),
    .dly(dly), .unprov_done(up_done));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Idle cycle after each access keeps strobes from re-rising in one step
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    reg_addr = a; wd = d; be_n = b; reg_wr = 1'b1;
    @(posedge clk); #1 reg_wr = 1'b0;
    @(posedge clk); #1;
  endtask
  task rd(input logic [11:0] a);
    reg_addr = a; be_n = 4'h0; reg_rd = 1'b1;
    @(posedge clk); #1 reg_rd = 1'b0; rv = rd_q;
    @(posedge clk); #1;
  endtask
  task count(input int s, input int n, input logic f);
    ev[s] = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk); #1;
      chk(irq[s], f && (i == n - 1));
    end
    ev[s] = 1'b0;
    @(posedge clk); #1;
  endtask
  function automatic int lim(input int s, input int k);
    if (s == 0) return k == 1 ? 4 : k == 2 ? 6 : k == 3 ? 8 :
                       k == 4 ? 16 : k == 5 ? 32 : 1;
    return k == 1 ? 4 : k == 2 ? 8 : 1;
  endfunction
  function automatic logic [31:0] da(input logic [31:0] b,
                                     input logic [14:0] o);
    return {b[31:4] + {13'h0, o}, 4'h0};
  endfunction
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #5000000 n_errors++;
    end_of_test;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 12'h0; be_n = 4'h0;
    wd = 32'h0; ev = 4'h0; ofs = 15'h0; dly = 4'h2;
    rv = $urandom(89239);
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    rd(OFS_CTRL); chk(rv & 32'h1fff, 32'h1e);
    chk({lfm, sfm, en}, 7'h6c);
    ctl = 13'h1e;
    for (int s = 0; s < 3; s++) begin
      old = 1;
      for (int k = 0; k < 8; k++) begin
        c = (s == 0) ? rc[k] : rc[k] & 3;
        case (s)
          0: ctl[7:5] = c[2:0];
          1: ctl[9:8] = c[1:0];
          default: ctl[11:10] = c[1:0];
        endcase
        ctl[2:1] = $urandom;
        wr(OFS_CTRL, {19'h0, ctl}, $urandom_range(0, 14));
        chk({lfm, sfm}, {ctl[1]?3'h6:3'h1, ctl[2]?3'h6:3'h1});
        count(s, old, 1);
        old = lim(s, c);
      end
      count(s, old, 1);
    end
    for (int r = 0; r < 4; r++) begin
      ctl[0] = 1'b1; ctl[4:3] = r[1:0];
      wr(OFS_CTRL, {19'h0, ctl}, 4'h0);
      chk(en, 1'b1);
      count(3, r + 1, 1);
    end
    wr(OFS_CTRL, 32'h0, 4'hf);
    rd(OFS_CTRL); chk(rv & 32'h1fff, {19'h0, ctl});
    ctl[0] = 1'b0;
    wr(OFS_CTRL, {19'h0, ctl}, 4'h0);
    count(3, 4, 0);
    rd(12'h2a0); chk(rv, 32'h0);
    for (int j = 0; j < 4; j++) begin
      c = $urandom_range(0, 255);
      dly = $urandom_range(4, 9);
      wr(OFS_PROVISION_FLAG, c, 4'h0);
      chk({ureq, uchan}, {1'b1, c[7:0]});
      // A trigger while the flush runs must be dropped entirely
      wr(OFS_PROVISION_FLAG, 32'h4000 | (c ^ 8'hff), 4'h0);
      rd(OFS_PROVISION_FLAG); chk(rv[15], 1'b1);
      for (int t = 0; t < 20 && rv[15] !== 1'b0; t++) rd(OFS_PROVISION_FLAG);
      chk({ureq, rv[15:0]}, {1'b0, 8'h0, c[7:0]});
      wr(OFS_PROVISION_FLAG, 32'h4000 | c, 4'h0);
      chk(ureq, 1'b0);
      rd(OFS_PROVISION_FLAG); chk(rv[15:0], 16'h4400 | c);
      wr(OFS_PROVISION_FLAG, 32'h400 | c, 4'h0);
      rd(OFS_PROVISION_FLAG); chk({ureq, rv[15:0]}, 17'h400 | c);
    end
    base_x = 32'h0;
    for (int j = 0; j < 6; j++) begin
      lo_w = 16'($urandom) & 16'hfff0;
      wr(OFS_TBL_LO, {16'h0, lo_w}, 4'h0);
      chk(base, base_x);
      rd(OFS_TBL_LO); chk(rv, {16'h0, lo_w});
      base_x = {16'($urandom), lo_w};
      wr(OFS_TBL_HI, base_x >> 16, $urandom_range(0, 14));
      chk(base, base_x);
      rd(OFS_TBL_HI); chk(rv, base_x >> 16);
      ofs = (j == 0) ? 15'h7fff : 15'($urandom);
      repeat (2) @(posedge clk);
      #1 chk(desc_addr, da(base_x, ofs));
    end
    end_of_test;
  end
endmodule
